/* rtl/itps_pkg.sv */
// Purpose: constants for the interrupt test and priority select block
// Assumes: 8-bit register port, offsets as byte addresses within the block
// Notes: rules of the block follow
// Function
// - enable bit always readable; writable only in special mode with I and X masks set
// - enable clear: test writes ignored, reads show live input lines
// - enable set: decoder fed only from written test bits
// - requests pending when enable sets stay until overwritten
// - 4-bit select field picks test group equal to vector nibble
// - test reads meaningful only in special mode, zero otherwise
// - test writes need special mode, enable set, I mask set
// - test bit n forces vector with low nibble 2n
// - one test register per eight sources, shared address, chosen by select
// - select F exposes only bits 2:0, upper bits read zero
// - unimplemented group: writes ignored, reads zero
// - promotion register readable always, writable only with I mask set
// - promotion field holds vector low byte, source ranks top among I sources
// - unimplemented or non-I promotion value defaults to IRQ vector F2
// - vector request returns highest valid pending vector at that moment
// - vanished request gives last valid vector; never pending gives software vector
// - fixed priority reset, clock monitor, watchdog, trap, swi, x_maskable_interrupt_pin, irq, others
package itps_pkg;
   localparam logic [7:0] ITPS_OFS_CTRL = 8'h15;
   localparam logic [7:0] ITPS_OFS_TEST = 8'h16;
   localparam logic [7:0] ITPS_OFS_PROMO = 8'h1F;
   localparam logic [7:0] ITPS_OFS_IRQ_STAT = 8'h20;
   localparam logic [7:0] ITPS_OFS_IRQ_EN = 8'h21;
   localparam logic [7:0] ITPS_OFS_IRQ_CLR = 8'h22;
   localparam int ITPS_WEN_BIT = 4;
   localparam logic [3:0] ITPS_SEL_TOP = 4'hF;
   localparam logic [7:0] ITPS_TOP_MASK = 8'h07;
   localparam logic [7:0] ITPS_VEC_IRQ = 8'hF2;
   localparam logic [7:0] ITPS_VEC_X_MASKABLE_INTERRUPT_PIN = 8'hF4;
   localparam logic [7:0] ITPS_VEC_SWI = 8'hF6;
   localparam logic [7:0] ITPS_VEC_TRAP = 8'hF8;
   localparam logic [7:0] ITPS_VEC_WDOG = 8'hFA;
   localparam logic [7:0] ITPS_VEC_CMON = 8'hFC;
   localparam logic [7:0] ITPS_VEC_RESET = 8'hFE;
   localparam logic [7:0] ITPS_PROMO_RST = 8'hF2;
   localparam logic [3:0] ITPS_SEL_RST = 4'hF;
   // interrupt status bits: vector served, test write refused
   localparam int ITPS_EV_VEC = 0;
   localparam int ITPS_EV_REFUSE = 1;
endpackage

/* rtl/itps_top.sv */
// Purpose: interrupt test registers, priority promotion and vector decode
// Assumes: synchronous inputs; i_int_lines bit 8*g+b is vector FF(g)(2b)
// Notes: group F holds x_maskable_interrupt_pin (bit2), irq (bit1) and source F0 (bit0)
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module itps_top import itps_pkg::*; #(
   parameter int NGRP = 16
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_special_mode,
   input wire logic i_ccr_i_mask,
   input wire logic i_ccr_x_mask,
   input wire logic [NGRP*8-1:0] i_int_lines,
   input wire logic i_req_reset,
   input wire logic i_req_cmon,
   input wire logic i_req_wdog,
   input wire logic i_req_trap,
   input wire logic i_req_swi,
   input wire logic i_vec_req,
   output logic [7:0] o_rdata,
   output logic [7:0] o_vector,
   output logic o_int_pending,
   output logic o_irq
);
   // refuse group counts that the 4-bit select field cannot reach
   if (NGRP < 1 || NGRP > 16) begin : g_bad_ngrp
      $error("itps_top: NGRP must be 1..16");
   end

   typedef struct packed {
      logic wen;
      logic [3:0] sel;
      logic [7:0] promo;
      logic [15:0][7:0] tbits;
      logic [7:0] last_vec;
      logic seen;
      logic [1:0] stat;
      logic [1:0] irq_en;
      logic [7:0] rdata;
      logic [7:0] vector;
      logic pend;
      logic irq;
   } itps_state_type;

   itps_state_type st_r, st_nxt;

   // mask of accessible bits for a group
   function automatic logic [7:0] itps_grp_mask(input logic [3:0] g);
      if (int'(g) >= NGRP) return 8'h00;
      if (g == ITPS_SEL_TOP) return ITPS_TOP_MASK;
      return 8'hFF;
   endfunction

   // promotion value valid only for implemented i-bit sources
   function automatic logic itps_promo_ok(input logic [7:0] v);
      if (v > ITPS_VEC_IRQ) return 1'b0;
      if (int'(v[7:4]) >= NGRP) return 1'b0;
      return 1'b1;
   endfunction

   logic [15:0][7:0] live;
   logic [15:0][7:0] req;
   logic [7:0] pr_eff;
   logic any_req;
   logic [7:0] best;
   logic wr_ctrl;
   logic wr_test;
   logic wr_promo;
   logic wr_irq_en;
   logic wr_irq_clr;
   logic ctrl_ok;
   logic promo_wr_ok;

   // register write strobes, one per writable offset (none for status), and their unlock conditions
   always_comb begin
      wr_ctrl = i_wr && (i_addr == ITPS_OFS_CTRL);
      wr_test = i_wr && (i_addr == ITPS_OFS_TEST);
      wr_promo = i_wr && (i_addr == ITPS_OFS_PROMO);
      wr_irq_en = i_wr && (i_addr == ITPS_OFS_IRQ_EN);
      wr_irq_clr = i_wr && (i_addr == ITPS_OFS_IRQ_CLR);
      ctrl_ok = i_special_mode && i_ccr_i_mask && i_ccr_x_mask;
      promo_wr_ok = i_ccr_i_mask;
   end

   // live inputs, zero for absent groups
   always_comb begin
      live = '0;
      for (int g = 0; g < NGRP; g++) begin
         live[g] = i_int_lines[g*8 +: 8] & itps_grp_mask(4'(g));
      end
   end

   // request set seen by the decoder
   always_comb begin
      req = st_r.wen ? st_r.tbits : live;
      pr_eff = itps_promo_ok(st_r.promo) ? st_r.promo : ITPS_VEC_IRQ;
   end

   // priority decode: fixed exceptions, x_maskable_interrupt_pin, promoted, then descending i sources
   always_comb begin
      any_req = 1'b1;
      best = ITPS_VEC_SWI;
      if (i_req_reset) begin
         best = ITPS_VEC_RESET;
      end else if (i_req_cmon) begin
         best = ITPS_VEC_CMON;
      end else if (i_req_wdog) begin
         best = ITPS_VEC_WDOG;
      end else if (i_req_trap) begin
         best = ITPS_VEC_TRAP;
      end else if (i_req_swi) begin
         best = ITPS_VEC_SWI;
      end else if (req[15][2] && !i_ccr_x_mask) begin
         best = ITPS_VEC_X_MASKABLE_INTERRUPT_PIN;
      end else if (req[pr_eff[7:4]][pr_eff[3:1]] && !i_ccr_i_mask) begin
         best = pr_eff;
      end else begin
         any_req = 1'b0;
         // irq pin (bit 121) down to source 00; x_maskable_interrupt_pin (bit 122) is not an i source
         if (!i_ccr_i_mask) begin
            for (int n = 0; n < 122; n++) begin
               if (!any_req && req[4'((121 - n) >> 3)][3'((121 - n) & 7)]) begin
                  any_req = 1'b1;
                  best = 8'((121 - n) * 2);
               end
            end
         end
      end
   end

   // next state: register writes, status events, vector fetch and read data
   always_comb begin
      logic [7:0] rv;
      logic [7:0] m;
      logic tw_ok;
      rv = 8'h00;
      m = itps_grp_mask(st_r.sel);
      tw_ok = i_special_mode && st_r.wen && i_ccr_i_mask;
      st_nxt = st_r;
      // control register: select always written, enable only when unlocked
      if (wr_ctrl) begin
         if (ctrl_ok) begin
            st_nxt.wen = i_wdata[ITPS_WEN_BIT];
            // capture pending lines when test mode turns on
            if (i_wdata[ITPS_WEN_BIT] && !st_r.wen) begin
               st_nxt.tbits = live;
            end
         end
         st_nxt.sel = i_wdata[3:0];
      end
      // test register: lands in the selected group, masked to its bits
      if (wr_test) begin
         if (tw_ok) begin
            st_nxt.tbits[st_r.sel] = i_wdata & m;
         end
      end
      // promotion register: bit 0 is not stored
      if (wr_promo) begin
         if (promo_wr_ok) begin
            st_nxt.promo = {i_wdata[7:1], 1'b0};
         end
      end
      // interrupt enable and write-one-to-clear status
      if (wr_irq_en) begin
         st_nxt.irq_en = i_wdata[1:0];
      end
      if (wr_irq_clr) begin
         st_nxt.stat = st_r.stat & ~i_wdata[1:0];
      end
      // remember the last valid vector in case the request vanishes
      if (any_req) begin
         st_nxt.last_vec = best;
         st_nxt.seen = 1'b1;
      end
      // vector fetch
      if (i_vec_req) begin
         if (any_req) begin
            st_nxt.vector = best;
         end else if (st_r.seen) begin
            st_nxt.vector = st_r.last_vec;
         end else begin
            st_nxt.vector = ITPS_VEC_SWI;
         end
      end
      // hardware set wins over software clear, so it comes last
      if (wr_test && !tw_ok) begin
         st_nxt.stat[ITPS_EV_REFUSE] = 1'b1;
      end
      if (i_vec_req) begin
         st_nxt.stat[ITPS_EV_VEC] = 1'b1;
      end
      // read mux
      case (i_addr)
         ITPS_OFS_CTRL: begin
            rv = {3'h0, st_r.wen, st_r.sel};
         end
         ITPS_OFS_TEST: begin
            if (!i_special_mode) begin
               rv = 8'h00;
            end else if (st_r.wen) begin
               rv = st_r.tbits[st_r.sel] & m;
            end else begin
               rv = live[st_r.sel] & m;
            end
         end
         ITPS_OFS_PROMO: begin
            rv = st_r.promo;
         end
         ITPS_OFS_IRQ_STAT: begin
            rv = {6'h00, st_r.stat};
         end
         ITPS_OFS_IRQ_EN: begin
            rv = {6'h00, st_r.irq_en};
         end
         default: begin
            rv = 8'h00;
         end
      endcase
      // read data stands for one cycle only
      if (i_rd) begin
         st_nxt.rdata = rv;
      end else begin
         st_nxt.rdata = 8'h00;
      end
      st_nxt.pend = any_req;
      st_nxt.irq = |(st_nxt.stat & st_nxt.irq_en);
   end

   // state register
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_r <= '0;
         st_r.sel <= ITPS_SEL_RST;
         st_r.promo <= ITPS_PROMO_RST;
         st_r.vector <= ITPS_VEC_SWI;
      end else if (i_ce) begin
         st_r <= st_nxt;
      end
   end

   assign o_rdata = st_r.rdata;
   assign o_vector = st_r.vector;
   assign o_int_pending = st_r.pend;
   assign o_irq = st_r.irq;
endmodule // itps_top

/* sim/itps_sva.sv */
// Purpose: port checks of itps_top
// Assumes: select sits in bits 3:0 of offset 15
// Notes: one clock domain
`timescale 1ns/1ps
module itps_sva (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_special_mode,
   input wire logic i_req_reset,
   input wire logic i_vec_req,
   input wire logic [7:0] o_rdata,
   input wire logic [7:0] o_vector,
   input wire logic o_int_pending
);
   logic [3:0] sel_r;
   // decoded reads
   wire logic rd_ctl = i_ce && i_rd && i_addr == 8'h15;
   wire logic rd_tst = i_ce && i_rd && i_addr == 8'h16;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   // shadow of the group select
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) sel_r <= 4'hF;
      else if (i_ce && i_wr && i_addr == 8'h15) sel_r <= i_wdata[3:0];
   end
   a_ctl_upper_zero: assert property ($past(rd_ctl) |-> o_rdata[7:5] == 3'h0)
      else $error("ctrl top");
   a_sel_readback: assert property ($past(rd_ctl) |-> o_rdata[3:0] == $past(sel_r))
      else $error("select");
   a_test_normal_zero: assert property ($past(rd_tst && !i_special_mode) |-> o_rdata == 8'h00)
      else $error("normal read");
   a_top_group_bits: assert property ($past(rd_tst && sel_r == 4'hF) |-> o_rdata[7:3] == 5'h00)
      else $error("group F");
   a_unmapped_zero: assert property ($past(i_ce && i_rd && i_addr > 8'h22) |-> o_rdata == 8'h00)
      else $error("unmapped");
   a_vector_held: assert property (!$past(i_vec_req) |-> $stable(o_vector))
      else $error("vector moved");
   a_reset_vector: assert property ($past(i_ce && i_vec_req && i_req_reset) |-> o_vector == 8'hFE)
      else $error("reset vector");
   a_reset_pending: assert property (i_ce && i_req_reset |=> o_int_pending)
      else $error("pending");
endmodule // itps_sva
bind itps_top itps_sva u_sva (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_special_mode(i_special_mode),
   .i_req_reset(i_req_reset), .i_vec_req(i_vec_req), .o_rdata(o_rdata),
   .o_vector(o_vector), .o_int_pending(o_int_pending));

/* sim/itps_cpu_model.sv */
// Purpose: cpu core side, asks for vectors
// Assumes: one fetch command gives one pulse
// Notes: pulse lands one cycle after the command
`timescale 1ns/1ps
module itps_cpu_model (
   input wire logic i_clk,
   input wire logic i_fetch,
   output logic o_vec_req = 1'b0
);
   // one-cycle vector fetch
   always @(posedge i_clk) o_vec_req <= i_fetch;
endmodule // itps_cpu_model

/* sim/test_interrupt_test_and_priority_select.sv */
// Purpose: self-checking bench of itps_top
// Assumes: all sixteen groups present
// Notes: ops rows are kind, offset, data
`timescale 1ns/1ps
module test_interrupt_test_and_priority_select;
   logic i_clk = 0, i_rst_b = 0, wr = 0, rd = 0, sm = 0, im = 1, xm = 1, fetch = 0;
   logic rq_trap = 0, rq_swi = 0, rq_reset = 0, vreq, rd_d = 0, vd = 0, pend, irq;
   logic [7:0] addr = 0, wd = 0, rdata, vec, rq[$], vq[$];
   logic [127:0] ln = 0;
   integer err_count = 0, comparisons = 0, seed = 95;
   logic [19:0] ops[$] = {20'h30018, 20'h01600, 20'h11513, 20'h01503,
      20'h30038, 20'h40000, 20'h11513, 20'h01513, 20'h400FF, 20'h01600,
      20'h11680, 20'h11511, 20'h11601, 20'h01601, 20'h11F10, 20'h30028, 20'h20010,
      20'h11F20, 20'h01F10, 20'h30038, 20'h1151F, 20'h11604, 20'h30020, 20'h200F4,
      20'h30024, 20'h200F8, 20'h30022, 20'h200F6, 20'h30021, 20'h200FE, 20'h30020,
      20'h02003, 20'h12103, 20'h50001, 20'h12203, 20'h50000, 20'h02000, 20'h04000};
   initial forever #4 i_clk = ~i_clk;
   itps_top DUT (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(1'b1), .i_addr(addr), .i_wdata(wd),
      .i_wr(wr), .i_rd(rd), .i_special_mode(sm), .i_ccr_i_mask(im), .i_ccr_x_mask(xm),
      .i_int_lines(ln), .i_req_reset(rq_reset), .i_req_cmon(1'b0), .i_req_wdog(1'b0),
      .i_req_trap(rq_trap), .i_req_swi(rq_swi), .i_vec_req(vreq), .o_rdata(rdata),
      .o_vector(vec), .o_int_pending(pend), .o_irq(irq));
   itps_cpu_model cpu (.i_clk(i_clk), .i_fetch(fetch), .o_vec_req(vreq));
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
      end
   endtask
   task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      {wr, rd, addr, wd} <= {w, !w, a, d};
      if (!w) rq.push_back(d);
      @(posedge i_clk);
      {wr, rd} <= 2'b00;
   endtask
   task fv(input logic [7:0] e);
      vq.push_back(e);
      @(posedge i_clk);
      fetch <= 1;
      @(posedge i_clk);
      fetch <= 0;
      repeat (2) @(posedge i_clk);
   endtask
   task give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // match each landed result with the oldest note
   always @(posedge i_clk) begin
      if (rd_d) chk(rdata, rq.pop_front());
      if (vd) chk(vec, vq.pop_front());
      rd_d <= rd;
      vd <= vreq;
   end
   // cut a hang short
   initial begin
      #40000;
      err_count++;
      give_verdict;
   end
   // reset, live inputs, then the ops table
   initial begin
      repeat (16) @(posedge i_clk);
      i_rst_b <= 1;
      acc(0, 8'h15, 8'h0F);
      acc(0, 8'h1F, 8'hF2);
      {sm, ln} <= {1'b1, $random(seed), $random(seed), $random(seed), $random(seed)};
      @(posedge i_clk);
      acc(0, 8'h16, ln[127:120] & 8'h07);
      acc(1, 8'h15, 8'h03);
      acc(0, 8'h16, ln[31:24]);
      acc(1, 8'h16, 8'hFF);
      acc(0, 8'h16, ln[31:24]);
      $display("live input test done");
      foreach (ops[i]) begin
         case (ops[i][19:16])
            0, 1: acc(ops[i][16], ops[i][15:8], ops[i][7:0]);
            2: fv(ops[i][7:0]);
            3: {sm, im, xm, rq_trap, rq_swi, rq_reset} <= ops[i][5:0];
            4: ln <= {16{ops[i][7:0]}};
            default: begin
               repeat (2) @(posedge i_clk);
               chk({7'h00, irq}, ops[i][7:0]);
            end
         endcase
      end
      repeat (3) @(posedge i_clk);
      $display("table test done");
      give_verdict;
   end
endmodule // test_interrupt_test_and_priority_select
